// File: rtl/slb_pkg.sv
// package: constants shared by both ends of the link self-test
package slb_pkg;
  // ---------------------------------------------------------------
  // widths and encodings
  // ---------------------------------------------------------------
  localparam int unsigned     PAYLOAD_W   = 16;
  localparam int unsigned     ERR_W       = 16;
  localparam int unsigned     LOCK_N      = 8;      // clean words before lock
  localparam logic [1:0]      SEL_EXT     = 2'h0;   // external pixel clock
  localparam logic [1:0]      SEL_50M     = 2'h1;
  localparam logic [1:0]      SEL_25M     = 2'h2;
  localparam logic [1:0]      SEL_12M     = 2'h3;
  // forward link clock divider per select code, in system clocks per half period
  localparam logic [3:0]      DIV_50M     = 4'h1;
  localparam logic [3:0]      DIV_25M     = 4'h2;
  localparam logic [3:0]      DIV_12M     = 4'h4;
  localparam logic [15:0]     PRBS_SEED   = 16'hace1;
  localparam logic [ERR_W-1:0] ERR_MAX    = {ERR_W{1'b1}};
  // lock wait time at the controller
  localparam int unsigned     CLK_MHZ     = 100;
  localparam int unsigned     LOCK_WAIT_MS = 10;
  localparam int unsigned     LOCK_WAIT_CYC = LOCK_WAIT_MS * 1000 * CLK_MHZ;

  // next prbs word: x^16+x^14+x^13+x^11 lfsr, advanced one bit
  function automatic logic [15:0] prbs_next(input logic [15:0] s);
    prbs_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // clock divider for a select code
  function automatic logic [3:0] sel_div(input logic [1:0] sel);
    case (sel)
      SEL_50M: sel_div = DIV_50M;
      SEL_25M: sel_div = DIV_25M;
      default: sel_div = DIV_12M;
    endcase
  endfunction
endpackage

// File: rtl/slb_link_if.sv
// interface: serial link between serializer and deserializer ends
`timescale 1ns/1ps
interface slb_link_if;
  logic                          test_cmd;     // back channel: enter test mode
  logic                          link_clk;     // forward link word clock
  logic [slb_pkg::PAYLOAD_W-1:0] link_data;    // forward payload word
  logic                          link_valid;   // payload is test pattern

  modport ser (input test_cmd, output link_clk, output link_data, output link_valid);
  modport des (output test_cmd, input link_clk, input link_data, input link_valid);
endinterface // slb_link_if

// File: rtl/slb_ser.sv
// module: serializer end, prbs generator in test mode
`timescale 1ns/1ps
module slb_ser (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  slb_link_if.ser                            link,
  input  wire logic                          mode_sel,      // low for camera
  input  wire logic                          ext_pclk,      // external pixel clock
  input  wire logic [1:0]                    clk_sel,
  input  wire logic [slb_pkg::PAYLOAD_W-1:0] par_data,      // normal parallel data
  input  wire logic                          bc_err,        // back-channel error seen
  output logic                               gpio0_err,
  output logic [slb_pkg::ERR_W-1:0]          err_count
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cmd_s_q, cmd_s_d, pclk_s_q, pclk_s_d, bce_s_q, bce_s_d;
  logic       pclk_prev_q, pclk_prev_d;
  logic       test_on;
  always_comb begin
    cmd_s_d     = {cmd_s_q[0], link.test_cmd};
    pclk_s_d    = {pclk_s_q[0], ext_pclk};
    bce_s_d     = {bce_s_q[0], bc_err};           // fault pin is asynchronous
    pclk_prev_d = pclk_s_q[1];
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_s_q     <= 2'h0;
      pclk_s_q    <= 2'h0;
      bce_s_q     <= 2'h0;
      pclk_prev_q <= 1'b0;
    end else begin
      cmd_s_q     <= cmd_s_d;
      pclk_s_q    <= pclk_s_d;
      bce_s_q     <= bce_s_d;
      pclk_prev_q <= pclk_prev_d;
    end
  end
  assign test_on = cmd_s_q[1] & ~mode_sel;

  // ---------------------------------------------------------------
  // word clock source, prbs and error count
  // ---------------------------------------------------------------
  logic [3:0]                    div_q, div_d;
  logic                          lclk_q, lclk_d;
  logic [15:0]                   prbs_q, prbs_d;
  logic [slb_pkg::PAYLOAD_W-1:0] data_q, data_d;
  logic                          vld_q, vld_d, gerr_q, gerr_d;
  logic [slb_pkg::ERR_W-1:0]     cnt_q, cnt_d;
  logic                          tick, rise;
  always_comb begin
    div_d  = div_q;
    lclk_d = lclk_q;
    tick   = 1'b0;
    if (clk_sel == slb_pkg::SEL_EXT) begin
      lclk_d = pclk_s_q[1];
    end else if (div_q + 4'h1 >= slb_pkg::sel_div(clk_sel)) begin
      div_d  = 4'h0;
      lclk_d = ~lclk_q;
    end else begin
      div_d = div_q + 4'h1;
    end
    rise   = lclk_d & ~lclk_q;
    tick   = rise;
    prbs_d = prbs_q;
    data_d = data_q;
    vld_d  = vld_q;
    if (!test_on) begin
      prbs_d = slb_pkg::PRBS_SEED;
      vld_d  = 1'b0;
      if (tick) data_d = par_data;
    end else if (tick) begin
      data_d = prbs_q;
      vld_d  = 1'b1;
      prbs_d = slb_pkg::prbs_next(prbs_q);
    end
    gerr_d = test_on & bce_s_q[1];
    cnt_d  = cnt_q;
    if (!test_on && cmd_s_q[1] == 1'b0 && vld_q) cnt_d = '0;
    else if (test_on && bce_s_q[1] && cnt_q != slb_pkg::ERR_MAX)
      cnt_d = cnt_q + 1'b1;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_q  <= 4'h0;
      lclk_q <= 1'b0;
      prbs_q <= slb_pkg::PRBS_SEED;
      data_q <= '0;
      vld_q  <= 1'b0;
      gerr_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      div_q  <= div_d;
      lclk_q <= lclk_d;
      prbs_q <= prbs_d;
      data_q <= data_d;
      vld_q  <= vld_d;
      gerr_q <= gerr_d;
      cnt_q  <= cnt_d;
    end
  end
  assign link.link_clk   = lclk_q;
  assign link.link_data  = data_q;
  assign link.link_valid = vld_q;
  assign gpio0_err       = gerr_q;
  assign err_count       = cnt_q;
endmodule // slb_ser

// File: rtl/slb_des.sv
// module: deserializer end, test control and prbs checker
`timescale 1ns/1ps
module slb_des (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  slb_link_if.des                   link,
  input  wire logic                 self_test_enable,
  input  wire logic                 power_enable_n,   // high = powered down
  input  wire logic                 mode_sel,         // high for camera
  output logic                      lock,
  output logic                      pass,
  output logic [slb_pkg::ERR_W-1:0] err_count
);
  // ---------------------------------------------------------------
  // synchronisers for pins and link
  // ---------------------------------------------------------------
  logic [1:0] en_s_q, en_s_d, pd_s_q, pd_s_d, lc_s_q, lc_s_d, lv_s_q, lv_s_d;
  logic       lc_prev_q, lc_prev_d;
  logic [slb_pkg::PAYLOAD_W-1:0] ld_s1_q, ld_s2_q;
  always_comb begin
    en_s_d    = {en_s_q[0], self_test_enable};
    pd_s_d    = {pd_s_q[0], power_enable_n};
    lc_s_d    = {lc_s_q[0], link.link_clk};
    lv_s_d    = {lv_s_q[0], link.link_valid};
    lc_prev_d = lc_s_q[1];
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_s_q <= 2'h0; pd_s_q <= 2'h0; lc_s_q <= 2'h0; lv_s_q <= 2'h0;
      lc_prev_q <= 1'b0;
      ld_s1_q <= '0;
      ld_s2_q <= '0;
    end else begin
      en_s_q <= en_s_d; pd_s_q <= pd_s_d; lc_s_q <= lc_s_d; lv_s_q <= lv_s_d;
      lc_prev_q <= lc_prev_d;
      ld_s1_q <= link.link_data;
      ld_s2_q <= ld_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // session state, lock, checker, pass flag
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_LOCK, ST_RUN} slb_state_t;
  slb_state_t                st_q, st_d;
  logic [3:0]                good_q, good_d;
  logic                      lock_q, lock_d, pass_q, pass_d, pd_prev_q, pd_prev_d;
  logic [15:0]               exp_q, exp_d;
  logic [slb_pkg::ERR_W-1:0] cnt_q, cnt_d;
  logic                      word, en, bad;
  always_comb begin
    en     = en_s_q[1] & mode_sel;
    word   = lc_s_q[1] & ~lc_prev_q & lv_s_q[1];      // word arrives on link clock rise
    bad    = word && (ld_s2_q != exp_q);
    st_d   = st_q;
    good_d = good_q;
    lock_d = lock_q;
    exp_d  = exp_q;
    cnt_d  = cnt_q;
    pass_d = pass_q;
    pd_prev_d = pd_s_q[1];
    case (st_q)
      ST_IDLE: begin
        good_d = 4'h0;
        lock_d = 1'b0;
        exp_d  = slb_pkg::PRBS_SEED;
        if (en) st_d = ST_WAIT_LOCK;
      end
      ST_WAIT_LOCK: begin
        if (!en) st_d = ST_IDLE;
        else if (word) begin
          exp_d  = slb_pkg::prbs_next(ld_s2_q);
          good_d = (ld_s2_q == exp_q) ? good_q + 4'h1 : 4'h0;
          if (good_q + 4'h1 >= 4'(slb_pkg::LOCK_N)) begin
            lock_d = 1'b1;
            st_d   = ST_RUN;
            cnt_d  = '0;
            pass_d = 1'b1;                            // new session starts clean
          end
        end
      end
      ST_RUN: begin
        if (!en) st_d = ST_IDLE;
        else if (word) begin
          exp_d = slb_pkg::prbs_next(exp_q);
          if (bad && cnt_q != slb_pkg::ERR_MAX) cnt_d = cnt_q + 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // result sticks low once a failure is seen in session
    if (st_q == ST_RUN && en && bad) pass_d = 1'b0;
    if (pd_prev_q && !pd_s_q[1]) pass_d = 1'b1;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      good_q <= 4'h0;
      lock_q <= 1'b0;
      pass_q <= 1'b1;
      pd_prev_q <= 1'b0;
      exp_q <= slb_pkg::PRBS_SEED;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      good_q <= good_d;
      lock_q <= lock_d;
      pass_q <= pass_d;
      pd_prev_q <= pd_prev_d;
      exp_q <= exp_d;
      cnt_q <= cnt_d;
    end
  end
  // live failure pulse: one clock low per failing word
  logic fail_pulse_q, fail_pulse_d;
  always_comb fail_pulse_d = (st_q == ST_RUN) && en && bad;
  always_ff @(posedge clock) begin
    if (sys_rst) fail_pulse_q <= 1'b0;
    else         fail_pulse_q <= fail_pulse_d;
  end
  assign link.test_cmd = en;
  assign lock      = lock_q;
  assign pass      = (st_q == ST_RUN) ? ~fail_pulse_q : pass_q;
  assign err_count = cnt_q;
endmodule // slb_des

// File: sim/slb_link_assertions.sv
// checker: link-side properties of the self-test handshake
`timescale 1ns/1ps
module slb_link_assertions (
  input wire logic                          clock,
  input wire logic                          sys_rst,
  input wire logic                          self_test_enable,
  input wire logic                          mode_sel,
  input wire logic                          test_cmd,
  input wire logic                          link_clk,
  input wire logic [slb_pkg::PAYLOAD_W-1:0] link_data,
  input wire logic                          link_valid
);
  // ---------------------------------------------------------------
  // properties on the joined link
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst_idle;
    $fell(sys_rst) |-> !test_cmd && !link_valid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
  property p_cmd_on;
    $rose(self_test_enable) && mode_sel |-> ##[1:4] test_cmd;
  endproperty
  a_cmd_on: assert property (p_cmd_on) else $error("no test command");
  property p_cmd_off;
    $fell(self_test_enable) |-> ##[1:4] !test_cmd;
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("test command kept");
  property p_camera_only;
    $rose(self_test_enable) && !mode_sel |-> !test_cmd [*8];
  endproperty
  a_camera_only: assert property (p_camera_only) else $error("test in display mode");
  property p_tx_start;
    $rose(test_cmd) |-> ##[1:40] link_valid;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("pattern never started");
  property p_tx_cause;
    $rose(link_valid) |-> test_cmd;
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("pattern without command");
  property p_tx_stop;
    $fell(test_cmd) |-> ##[1:40] !link_valid;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("pattern kept after test");
  property p_word_moves;
    link_valid && $rose(link_clk) && $past(link_valid) |-> ##[0:2] $changed(link_data);
  endproperty
  a_word_moves: assert property (p_word_moves) else $error("pattern word stuck");
endmodule // slb_link_assertions

// File: sim/serial_link_at_speed_bist_test.sv
// testbench: both link ends joined, self-test sessions and fault injection
`timescale 1ns/1ps
module serial_link_at_speed_bist_test;
  logic                          clock, sys_rst, self_test_enable, power_enable_n;
  logic                          ext_pclk, bc_err, ser_mode, des_mode, gpio, gseen;
  logic                          lock_a, pass_a, lock_b, pass_b;
  logic [1:0]                    clk_sel;
  logic [slb_pkg::PAYLOAD_W-1:0] par_data, flip;
  logic [slb_pkg::ERR_W-1:0]     ec_a, ec_b, ec_s;
  int                            fail_count, checks, pulses;
  slb_link_if lk ();
  slb_link_if lk2 ();
  // second deserializer sees the same stream with injected bit flips
  assign lk2.link_clk   = lk.link_clk;
  assign lk2.link_valid = lk.link_valid;
  assign lk2.link_data  = lk.link_data ^ flip;
  slb_ser i_slb_ser (.clock, .sys_rst, .link(lk), .mode_sel(ser_mode), .ext_pclk, .clk_sel,
    .par_data, .bc_err, .gpio0_err(gpio), .err_count(ec_s));
  slb_des i_slb_des (.clock, .sys_rst, .link(lk), .self_test_enable, .power_enable_n,
    .mode_sel(des_mode), .lock(lock_a), .pass(pass_a), .err_count(ec_a));
  slb_des i_slb_des_2 (.clock, .sys_rst, .link(lk2), .self_test_enable, .power_enable_n,
    .mode_sel(des_mode), .lock(lock_b), .pass(pass_b), .err_count(ec_b));
  slb_link_assertions i_chk (.clock, .sys_rst, .self_test_enable, .mode_sel(des_mode),
    .test_cmd(lk.test_cmd), .link_clk(lk.link_clk), .link_data(lk.link_data),
    .link_valid(lk.link_valid));
  // ---------------------------------------------------------------
  // clocks and helpers
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // external pixel clock for select 00
  initial begin
    ext_pclk = 1'b0;
    forever #80 ext_pclk = ~ext_pclk;
  end
  // sticky copy of the back-channel fault flag
  always @(posedge clock) if (gpio === 1'b1) gseen <= 1'b1;
  // count live fail pulses on the second end while locked, settled at falling edge
  always @(negedge clock) if (lock_b === 1'b1 && pass_b === 1'b0) pulses++;
  task automatic chk(input logic [15:0] a, input logic [15:0] e, input string m);
    checks++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wlock();
    int n;
    n = 0;
    while (lock_a !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
  endtask
  // corrupt exactly one word on the second link
  task automatic bad_word();
    @(posedge lk.link_clk);
    @(negedge clock) flip = 16'h0001;
    @(posedge lk.link_clk);
    @(negedge clock) flip = 16'h0000;
  endtask
  task automatic t_sel(input logic [1:0] s);
    clk_sel = s;
    self_test_enable = 1'b1;
    wlock();
    chk(lk.test_cmd, 1'b1, "no test command");
    chk(lock_a, 1'b1, "no lock");
    repeat (100) @(negedge clock);
    chk(pass_a & lock_a, 1'b1, "clean run failed");
    chk(ec_a, 16'h0000, "clean run counted");
    self_test_enable = 1'b0;
    repeat (40) @(negedge clock);
    chk(lock_a, 1'b0, "lock kept");
    chk(lk.link_data, par_data, "normal data not resumed");
    chk(lk.link_valid, 1'b0, "pattern kept after test");
    $display("test clock select %0d done", s);
  endtask
  task automatic t_err();
    clk_sel = 2'h3;
    self_test_enable = 1'b1;
    wlock();
    pulses = 0;
    bad_word();
    bad_word();
    repeat (40) @(negedge clock);
    chk(pulses, 16'h0002, "error not flagged");
    chk(ec_b, 16'h0002, "error count wrong");
    chk(pass_a, 1'b1, "clean end disturbed");
    self_test_enable = 1'b0;
    repeat (3) @(negedge clock);
    flip = 16'h00ff;
    repeat (40) @(negedge clock);
    flip = 16'h0000;
    chk(ec_b, 16'h0002, "late error counted");
    chk(pass_b, 1'b0, "result not held");
    power_enable_n = 1'b1;
    repeat (4) @(negedge clock);
    power_enable_n = 1'b0;
    repeat (4) @(negedge clock);
    chk(pass_b, 1'b1, "power toggle kept fail");
    $display("test error injection done");
  endtask
  task automatic t_bc();
    clk_sel = 2'h1;
    self_test_enable = 1'b1;
    wlock();
    chk(gseen, 1'b0, "flag before fault");
    bc_err = 1'b1;
    @(negedge clock);
    bc_err = 1'b0;
    repeat (6) @(negedge clock);
    chk(gseen, 1'b1, "fault not flagged");
    chk(ec_s, 16'h0001, "fault count wrong");
    self_test_enable = 1'b0;
    repeat (40) @(negedge clock);
    $display("test back channel fault done");
  endtask
  task automatic t_mode();
    des_mode = 1'b0;
    self_test_enable = 1'b1;
    repeat (200) @(negedge clock);
    chk(lk.test_cmd, 1'b0, "test in display mode");
    chk(lock_a, 1'b0, "lock in display mode");
    self_test_enable = 1'b0;
    repeat (4) @(negedge clock);
    des_mode = 1'b1;
    $display("test display mode done");
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {sys_rst, ser_mode, des_mode, par_data} = {3'b101, 16'h5a5a};
    {self_test_enable, power_enable_n, bc_err, gseen, clk_sel, flip} = '0;
    {fail_count, checks, pulses} = '0;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    for (int s = 0; s < 4; s++) t_sel(2'(s));
    t_err();
    t_bc();
    t_mode();
    conclude();
  end
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule // serial_link_at_speed_bist_test
